// >>> hdl/twse_defs.svh
// Constants for the two-wire slave-receive end and bus error block.
// Assumes byte addresses on a 32-bit Avalon-MM slave and a 200 MHz clock.
`ifndef TWSE_DEFS_SVH
`define TWSE_DEFS_SVH
// Register word offsets, matched against address bits 3:2
`define TWSE_OFS_CTRL 2'h0
`define TWSE_OFS_STAT 2'h1
`define TWSE_OFS_DATA 2'h2
`define TWSE_OFS_ADDR 2'h3
// Control field positions
`define TWSE_CB_DONE 7
`define TWSE_CB_ACK 6
`define TWSE_CB_BEGIN 5
`define TWSE_CB_END 4
`define TWSE_CB_EN 2
// Reset values
`define TWSE_RST_CTRL 8'h00
`define TWSE_RST_PRESC 2'h0
`define TWSE_RST_ADDR 8'h02
`define TWSE_RST_DATA 8'h01
// Status codes, upper five bits significant
`define TWSE_ST_IDLE 8'hF8
`define TWSE_ST_IDLE_HI 5'h1F
`define TWSE_ST_BERR 8'h00
`define TWSE_ST_START 8'h08
`define TWSE_ST_RSTART 8'h10
`define TWSE_ST_SLA 8'h60
`define TWSE_ST_GCA 8'h70
`define TWSE_ST_DACK 8'h80
`define TWSE_ST_DNACK 8'h88
`define TWSE_ST_GDACK 8'h90
`define TWSE_ST_GDNACK 8'h98
`define TWSE_ST_STOPRX 8'hA0
`define TWSE_GCALL 7'h00
// Timing: half bit phase of generated conditions
`define TWSE_CLK_NS 5
`define TWSE_T_HALF_NS 5000
`define TWSE_T_HALF_CYC ((`TWSE_T_HALF_NS + `TWSE_CLK_NS - 1) / `TWSE_CLK_NS)
`endif

// >>> hdl/twse_pkg.sv
// Types for the two-wire slave-receive end and bus error block.
// Constants live in twse_defs.svh; this package holds types only.
package twse_pkg;
	// Block states, one-hot
	typedef enum logic [8:0] {
		S_IDLE = 9'h001,
		S_ADDR = 9'h002,
		S_AACK = 9'h004,
		S_DATA = 9'h008,
		S_DACK = 9'h010,
		S_HOLD = 9'h020,
		S_MSTART = 9'h040,
		S_MOWN = 9'h080,
		S_MSTOP = 9'h100
	} twse_state_e;
	// Software control bits
	typedef struct packed {
		logic step_done;
		logic ack_enable;
		logic begin_request;
		logic end_condition_request;
		logic enable;
	} twse_ctrl_s;
	// Line drive pair
	typedef struct packed {
		logic scl;
		logic sda;
	} twse_lines_s;
endpackage

// >>> hdl/twse_top.sv
// Two-wire unit: slave receive, end-of-transfer handling, bus error and START ownership.
// Assumes open-drain SCL/SDA outside, pin inputs asynchronous, one 200 MHz clock.
//
// Overview of operation
// - STOP/restart while addressed reports 0xA0, then unaddressed
// - Recognition of own and broadcast follows ack-enable
// - Begin request queues START until bus free
// - Status reads 0xF8 plus the prescaler bits while step-done is clear
// - Misplaced START/STOP inside frame gives status 0x00
// - Bus error sets step-done flag
// - Recovery unaddresses and clears end request and bus-busy only
// - Recovery releases lines, sends no STOP
// - Repeated START keeps bus ownership as master
// - Status holds 5-bit code above prescaler bits
// - Address LSB enables broadcast address recognition
`include "twse_defs.svh"
`timescale 1ns/10ps
`default_nettype none
module twse_top
	import twse_pkg::*;
(
	input wire logic MCLK_I,
	input wire logic RST_I,
	input wire logic [3:0] AVS_ADDRESS_I,
	input wire logic AVS_READ_I,
	input wire logic AVS_WRITE_I,
	input wire logic [31:0] AVS_WRITEDATA_I,
	input wire logic [3:0] AVS_BYTEENABLE_I,
	output logic [31:0] AVS_READDATA_O,
	output logic AVS_WAITREQUEST_O,
	input wire logic SCL_I,
	output logic SCL_O,
	output logic SCL_OE_N_O,
	input wire logic SDA_I,
	output logic SDA_O,
	output logic SDA_OE_N_O
);
	localparam logic [9:0] T_HALF = 10'(`TWSE_T_HALF_CYC); // Condition phase length
	// Pin synchronisers, third stage for edges
	logic [2:0] scl_sy_r, scl_sy_nxt;
	logic [2:0] sda_sy_r, sda_sy_nxt;
	// Main state
	twse_state_e st_r, st_nxt;
	twse_ctrl_s ctrl_r, ctrl_nxt; // Software control bits
	twse_lines_s drv_r, drv_nxt; // Lines pulled low when set
	logic [7:0] code_r, code_nxt; // Status code behind the flag
	logic [1:0] presc_r, presc_nxt; // Prescaler field
	logic [7:0] oar_r, oar_nxt; // Own address and broadcast enable
	logic [7:0] data_r, data_nxt; // Last byte received
	logic [7:0] sh_r, sh_nxt; // Receive shifter
	logic [3:0] cnt_r, cnt_nxt; // Bits in current byte
	logic [1:0] ph_r, ph_nxt; // Sub-phase
	logic [9:0] tmr_r, tmr_nxt; // Condition timer
	logic gc_r, gc_nxt; // Addressed by broadcast
	logic ackp_r, ackp_nxt; // Acknowledge planned for next byte
	logic endst_r, endst_nxt; // Held state ends the transfer
	logic berr_r, berr_nxt; // Held state is a bus error
	logic busy_r, busy_nxt; // Bus between START and STOP
	logic own_r, own_nxt; // Bus owned as master
	logic done_r, done_nxt; // Bus access answered this cycle
	logic [7:0] rd_r, rd_nxt; // Read data
	// Derived events
	logic scl_rise, scl_fall, cond_start, cond_stop;
	logic acc_wr, acc_rd;
	logic [7:0] stat_view;
	logic addr_hit, gc_hit;

	// Sync next values
	always_comb begin
		scl_sy_nxt = {scl_sy_r[1:0], SCL_I};
		sda_sy_nxt = {sda_sy_r[1:0], SDA_I};
	end

	// Sync registers
	always_ff @(posedge MCLK_I) begin
		if (RST_I) begin
			scl_sy_r <= 3'h7;
			sda_sy_r <= 3'h7;
		end else begin
			scl_sy_r <= scl_sy_nxt;
			sda_sy_r <= sda_sy_nxt;
		end
	end

	// Edges and conditions from synced stages only
	assign scl_rise = scl_sy_r[1] & ~scl_sy_r[2];
	assign scl_fall = ~scl_sy_r[1] & scl_sy_r[2];
	assign cond_start = scl_sy_r[1] & scl_sy_r[2] & sda_sy_r[2] & ~sda_sy_r[1];
	assign cond_stop = scl_sy_r[1] & scl_sy_r[2] & ~sda_sy_r[2] & sda_sy_r[1];

	// One wait state per access; write lands when waitrequest drops
	assign AVS_WAITREQUEST_O = (AVS_READ_I | AVS_WRITE_I) & ~done_r;
	assign acc_wr = AVS_WRITE_I & done_r & AVS_BYTEENABLE_I[0];
	assign acc_rd = AVS_READ_I & ~done_r;
	assign AVS_READDATA_O = {24'h000000, rd_r};

	// Status view: idle code whenever the flag is down
	// Prescaler always readable, so software masks it before comparing codes
	assign stat_view = {(ctrl_r.step_done ? code_r[7:3] : `TWSE_ST_IDLE_HI), 1'b0, presc_r};
	// Address match, gated by ack enable
	assign addr_hit = ctrl_r.ack_enable & (sh_r[7:1] == oar_r[7:1]) & ~sh_r[0];
	assign gc_hit = ctrl_r.ack_enable & oar_r[0] & (sh_r[7:1] == `TWSE_GCALL);
	// Open-drain outputs: enable low while pulling low
	assign SCL_O = 1'b0;
	assign SDA_O = 1'b0;
	assign SCL_OE_N_O = ~drv_r.scl;
	assign SDA_OE_N_O = ~drv_r.sda;

	// Main next-state logic
	always_comb begin
		st_nxt = st_r;
		{ctrl_nxt, drv_nxt, code_nxt} = {ctrl_r, drv_r, code_r};
		{presc_nxt, oar_nxt, data_nxt} = {presc_r, oar_r, data_r};
		{sh_nxt, cnt_nxt, ph_nxt} = {sh_r, cnt_r, ph_r};
		tmr_nxt = (tmr_r != 10'h000) ? tmr_r - 10'h001 : tmr_r;
		{gc_nxt, ackp_nxt, endst_nxt, berr_nxt} = {gc_r, ackp_r, endst_r, berr_r};
		{busy_nxt, own_nxt} = {busy_r, own_r};
		done_nxt = (AVS_READ_I | AVS_WRITE_I) & ~done_r;
		rd_nxt = rd_r;
		// Register reads, unmapped words read zero
		if (acc_rd) begin
			case (AVS_ADDRESS_I[3:2])
				`TWSE_OFS_CTRL: rd_nxt = {ctrl_r.step_done, ctrl_r.ack_enable, ctrl_r.begin_request,
					ctrl_r.end_condition_request, 1'b0, ctrl_r.enable, 2'h0};
				`TWSE_OFS_STAT: rd_nxt = stat_view;
				`TWSE_OFS_DATA: rd_nxt = data_r;
				`TWSE_OFS_ADDR: rd_nxt = oar_r;
				default: rd_nxt = 8'h00;
			endcase
		end
		// Register writes; flag clears on writing one
		if (acc_wr) begin
			case (AVS_ADDRESS_I[3:2])
				`TWSE_OFS_CTRL: begin
					if (AVS_WRITEDATA_I[`TWSE_CB_DONE]) begin
						ctrl_nxt.step_done = 1'b0;
					end
					ctrl_nxt.ack_enable = AVS_WRITEDATA_I[`TWSE_CB_ACK];
					ctrl_nxt.begin_request = AVS_WRITEDATA_I[`TWSE_CB_BEGIN];
					ctrl_nxt.end_condition_request = AVS_WRITEDATA_I[`TWSE_CB_END];
					ctrl_nxt.enable = AVS_WRITEDATA_I[`TWSE_CB_EN];
				end
				`TWSE_OFS_STAT: presc_nxt = AVS_WRITEDATA_I[1:0];
				`TWSE_OFS_DATA: data_nxt = AVS_WRITEDATA_I[7:0];
				`TWSE_OFS_ADDR: oar_nxt = AVS_WRITEDATA_I[7:0];
				default: ;
			endcase
		end
		// Bus busy tracking for queued START
		if (cond_start) begin
			busy_nxt = 1'b1;
		end else if (cond_stop) begin
			busy_nxt = 1'b0;
		end
		case (st_r)
			// Idle: watch for START, or send a queued one on a free bus
			S_IDLE: begin
				if (!ctrl_r.enable) begin
					st_nxt = S_IDLE;
				end else if (cond_start) begin
					st_nxt = S_ADDR;
					cnt_nxt = 4'h0;
				end else if (ctrl_r.begin_request && !busy_r && !ctrl_r.step_done) begin
					st_nxt = S_MSTART;
					ph_nxt = 2'h0;
					tmr_nxt = T_HALF;
				end
			end
			// Address byte shifting
			S_ADDR: begin
				if ((cond_start || cond_stop) && cnt_r != 4'h0) begin
					code_nxt = `TWSE_ST_BERR;
					ctrl_nxt.step_done = 1'b1;
					berr_nxt = 1'b1;
					endst_nxt = 1'b1;
					st_nxt = S_HOLD;
				end else if (cond_stop) begin
					st_nxt = S_IDLE;
				end else if (scl_rise) begin
					sh_nxt = {sh_r[6:0], sda_sy_r[1]};
					cnt_nxt = cnt_r + 4'h1;
				end else if (cnt_r == 4'h8) begin
					// Not for us: drop back to unaddressed
					st_nxt = (addr_hit || gc_hit) ? S_AACK : S_IDLE;
					gc_nxt = gc_hit & ~addr_hit;
					ph_nxt = 2'h0;
				end
			end
			// Address or data acknowledge bit
			S_AACK, S_DACK: begin
				if (cond_start || cond_stop) begin
					code_nxt = `TWSE_ST_BERR;
					ctrl_nxt.step_done = 1'b1;
					berr_nxt = 1'b1;
					endst_nxt = 1'b1;
					drv_nxt.sda = 1'b0;
					st_nxt = S_HOLD;
				end else if (scl_fall && ph_r == 2'h0) begin
					drv_nxt.sda = (st_r == S_AACK) | ackp_r;
					ph_nxt = 2'h1;
				end else if (scl_fall) begin
					// Ninth clock done: report, and stall unless the held state ends the transfer
					drv_nxt.sda = 1'b0;
					drv_nxt.scl = 1'b1;
					ctrl_nxt.step_done = 1'b1;
					berr_nxt = 1'b0;
					st_nxt = S_HOLD;
					if (st_r == S_AACK) begin
						code_nxt = gc_r ? `TWSE_ST_GCA : `TWSE_ST_SLA;
						endst_nxt = 1'b0;
					end else begin
						data_nxt = sh_r;
						endst_nxt = ~ackp_r;
						code_nxt = gc_r ? (ackp_r ? `TWSE_ST_GDACK : `TWSE_ST_GDNACK)
							: (ackp_r ? `TWSE_ST_DACK : `TWSE_ST_DNACK);
					end
				end
			end
			// Data byte shifting
			S_DATA: begin
				if ((cond_start || cond_stop) && cnt_r <= 4'h1) begin
					// End of transfer: condition inside the first bit's high phase
					code_nxt = `TWSE_ST_STOPRX;
					ctrl_nxt.step_done = 1'b1;
					berr_nxt = 1'b0;
					endst_nxt = 1'b1;
					st_nxt = S_HOLD;
				end else if (cond_start || cond_stop) begin
					code_nxt = `TWSE_ST_BERR;
					ctrl_nxt.step_done = 1'b1;
					berr_nxt = 1'b1;
					endst_nxt = 1'b1;
					st_nxt = S_HOLD;
				end else if (scl_rise) begin
					sh_nxt = {sh_r[6:0], sda_sy_r[1]};
					cnt_nxt = cnt_r + 4'h1;
				end else if (cnt_r == 4'h8) begin
					st_nxt = S_DACK;
					ph_nxt = 2'h0;
				end
			end
			// Waiting for software to clear the flag
			S_HOLD: begin
				drv_nxt.scl = ctrl_r.step_done & ~endst_r;
				if (!ctrl_r.step_done) begin
					drv_nxt.scl = 1'b0;
					if (endst_r) begin
						// Unaddressed; ack enable decides next recognition
						st_nxt = S_IDLE;
						if (berr_r && ctrl_r.end_condition_request) begin
							// Internal reset only, lines free, no STOP
							ctrl_nxt.end_condition_request = 1'b0;
							drv_nxt = 2'b00;
							busy_nxt = 1'b0;
						end
					end else begin
						st_nxt = S_DATA;
						cnt_nxt = 4'h0;
						ackp_nxt = ctrl_r.ack_enable;
					end
				end
			end
			// START or repeated START generation
			S_MSTART: begin
				if (tmr_r == 10'h000) begin
					tmr_nxt = T_HALF;
					ph_nxt = ph_r + 2'h1;
					case (ph_r)
						2'h0: drv_nxt = 2'b00;
						2'h1: drv_nxt.sda = 1'b1;
						default: begin
							drv_nxt.scl = 1'b1;
							code_nxt = own_r ? `TWSE_ST_RSTART : `TWSE_ST_START;
							own_nxt = 1'b1;
							ctrl_nxt.step_done = 1'b1;
							ctrl_nxt.begin_request = 1'b0;
							st_nxt = S_MOWN;
						end
					endcase
				end
			end
			// Bus owned: stall, then repeat START or STOP
			S_MOWN: begin
				drv_nxt.scl = 1'b1;
				if (!ctrl_r.step_done && ctrl_r.begin_request) begin
					st_nxt = S_MSTART;
					ph_nxt = 2'h0;
					tmr_nxt = T_HALF;
				end else if (!ctrl_r.step_done && ctrl_r.end_condition_request) begin
					st_nxt = S_MSTOP;
					ph_nxt = 2'h0;
					drv_nxt.sda = 1'b1;
					tmr_nxt = T_HALF;
				end
			end
			// STOP generation, gives the bus up
			S_MSTOP: begin
				if (tmr_r == 10'h000) begin
					tmr_nxt = T_HALF;
					ph_nxt = ph_r + 2'h1;
					case (ph_r)
						2'h0: drv_nxt.scl = 1'b0;
						2'h1: drv_nxt.sda = 1'b0;
						default: begin
							own_nxt = 1'b0;
							ctrl_nxt.end_condition_request = 1'b0;
							st_nxt = S_IDLE;
						end
					endcase
				end
			end
			default: st_nxt = S_IDLE;
		endcase
	end

	// Main registers
	always_ff @(posedge MCLK_I) begin
		if (RST_I) begin
			st_r <= S_IDLE;
			{ctrl_r, drv_r} <= 7'h00;
			{code_r, presc_r} <= {`TWSE_ST_IDLE, `TWSE_RST_PRESC};
			{oar_r, data_r} <= {`TWSE_RST_ADDR, `TWSE_RST_DATA};
			{sh_r, cnt_r, ph_r, tmr_r} <= 24'h000000;
			{gc_r, ackp_r, endst_r, berr_r, busy_r, own_r, done_r} <= 7'h00;
			rd_r <= 8'h00;
		end else begin
			st_r <= st_nxt;
			{ctrl_r, drv_r, code_r} <= {ctrl_nxt, drv_nxt, code_nxt};
			{presc_r, oar_r, data_r} <= {presc_nxt, oar_nxt, data_nxt};
			{sh_r, cnt_r, ph_r, tmr_r} <= {sh_nxt, cnt_nxt, ph_nxt, tmr_nxt};
			{gc_r, ackp_r, endst_r, berr_r} <= {gc_nxt, ackp_nxt, endst_nxt, berr_nxt};
			{busy_r, own_r, done_r, rd_r} <= {busy_nxt, own_nxt, done_nxt, rd_nxt};
		end
	end
endmodule // twse_top
`default_nettype wire

// >>> tb/twse_props.sv
// Port checks for the two-wire slave end and bus error block.
// Bound to twse_top; sees only its ports, one clock domain.
`timescale 1ns/10ps
`default_nettype none
module twse_props (
	input wire logic MCLK_I,
	input wire logic RST_I,
	input wire logic [3:0] AVS_ADDRESS_I,
	input wire logic AVS_READ_I,
	input wire logic AVS_WRITE_I,
	input wire logic [31:0] AVS_READDATA_O,
	input wire logic AVS_WAITREQUEST_O,
	input wire logic SCL_I,
	input wire logic SCL_OE_N_O,
	input wire logic SDA_OE_N_O
);
	default clocking cb @(posedge MCLK_I);
	endclocking
	default disable iff (RST_I);
	// Read finishing in this cycle
	sequence s_rd_done;
		AVS_READ_I && !AVS_WAITREQUEST_O;
	endsequence
	// Same, on the status word
	sequence s_stat_rd;
		s_rd_done ##0 AVS_ADDRESS_I[3:2] == 2'h1;
	endsequence
	localparam logic [10:0] GAP_MIN = 11'h3DE; // 990 cycles
	localparam logic [10:0] GAP_MAX = 11'h3F2; // 1010 cycles
	logic sda_oe_q; // Data enable one cycle back
	logic gap_on; // START phase being timed
	logic [10:0] gap_cnt; // Cycles since data was pulled under a high clock
	// Times the START phase; too long for a delay range
	always_ff @(posedge MCLK_I) begin
		if (RST_I) begin
			sda_oe_q <= 1'b1;
			gap_on <= 1'b0;
			gap_cnt <= 11'h000;
		end else begin
			sda_oe_q <= SDA_OE_N_O;
			if (sda_oe_q && !SDA_OE_N_O && SCL_I) begin
				gap_on <= 1'b1;
				gap_cnt <= 11'h000;
			end else if (gap_on && !SCL_OE_N_O) begin
				gap_on <= 1'b0;
			end else if (gap_on) begin
				gap_cnt <= gap_cnt + 11'h001;
			end
		end
	end
	property p_wait_first;
		$rose(AVS_READ_I || AVS_WRITE_I) |-> AVS_WAITREQUEST_O;
	endproperty
	a_wait_first: assert property (p_wait_first) else $error("no wait in first access cycle");
	property p_wait_one;
		AVS_WAITREQUEST_O |=> !AVS_WAITREQUEST_O;
	endproperty
	a_wait_one: assert property (p_wait_one) else $error("wait longer than one cycle");
	property p_rd_upper;
		s_rd_done |-> AVS_READDATA_O[31:8] == 24'h000000;
	endproperty
	a_rd_upper: assert property (p_rd_upper) else $error("upper read data not zero");
	// Codes are multiples of eight above the prescaler pair
	property p_stat_code;
		s_stat_rd |-> !AVS_READDATA_O[2] && AVS_READDATA_O[7:3] inside {5'h1F, 5'h00, 5'h01, 5'h02,
			5'h0C, 5'h0E, 5'h10, 5'h11, 5'h12, 5'h13, 5'h14};
	endproperty
	a_stat_code: assert property (p_stat_code) else $error("illegal status code");
	property p_rst_rel;
		$fell(RST_I) |-> SCL_OE_N_O && SDA_OE_N_O;
	endproperty
	a_rst_rel: assert property (p_rst_rel) else $error("lines not released after reset");
	// A stretch must last, not glitch
	property p_stretch;
		$fell(SCL_OE_N_O) && !SCL_I |-> !SCL_OE_N_O [*8];
	endproperty
	a_stretch: assert property (p_stretch) else $error("clock stretch too short");
	property p_ack_hold;
		$fell(SDA_OE_N_O) && !SCL_I |-> !SDA_OE_N_O [*8];
	endproperty
	a_ack_hold: assert property (p_ack_hold) else $error("acknowledge dropped early");
	// Half bit phase between data and clock edges of a START
	property p_start_gap;
		gap_on && $fell(SCL_OE_N_O) |-> gap_cnt >= GAP_MIN && gap_cnt <= GAP_MAX;
	endproperty
	a_start_gap: assert property (p_start_gap) else $error("START timing wrong");
	// Clock must follow data within the phase, never hang
	property p_start_late;
		gap_on |-> gap_cnt <= GAP_MAX;
	endproperty
	a_start_late: assert property (p_start_late) else $error("START clock edge missing");
endmodule // twse_props
`default_nettype wire

// >>> tb/twse_bus_model.sv
// Master on the shared two-wire bus, bit period 160 ns.
// Assumes pull-ups resolved by the bench; honours clock stretching.
`timescale 1ns/10ps
`default_nettype none
module twse_bus_model (
	input wire logic scl_i,
	input wire logic sda_i,
	output logic scl_rel_o,
	output logic sda_rel_o
);
	logic got_ack; // Data line low in ninth clock
	int stalls; // Stretches that never ended
	initial begin
		scl_rel_o = 1'b1;
		sda_rel_o = 1'b1;
		stalls = 0;
	end
	// Release clock and wait for it, the device may hold it low
	task automatic rise;
		int n;
		#40 scl_rel_o = 1'b1;
		for (n = 0; n < 4000 && scl_i !== 1'b1; n++) #10;
		if (scl_i !== 1'b1) stalls++;
		#80 got_ack = !sda_i;
	endtask
	// START for 1, STOP for 0: data edge while clock high
	task automatic cond(input logic first);
		sda_rel_o = first;
		rise();
		sda_rel_o = !first;
		#80 scl_rel_o = !first;
		#80;
	endtask
	// n bits MSB first, ack clock after a whole byte
	task automatic xfer(input logic [7:0] b, input int n);
		for (int i = 0; i < n + (n == 8); i++) begin
			sda_rel_o = (i < 8) ? b[7 - i] : 1'b1;
			rise();
			scl_rel_o = 1'b0;
			#40;
		end
	endtask
endmodule // twse_bus_model
`default_nettype wire

// >>> tb/tb_top.sv
// Self-checking bench for twse_top with a bus master model on the lines.
// Assumes pull-ups on both lines and a 200 MHz clock.
`timescale 1ns/10ps
`default_nettype none
module tb_top;
	logic MCLK_I = 1'b0;
	logic RST_I = 1'b1;
	logic [3:0] AVS_ADDRESS_I = 4'h0;
	logic AVS_READ_I = 1'b0;
	logic AVS_WRITE_I = 1'b0;
	logic [31:0] AVS_WRITEDATA_I = 32'h0;
	logic [31:0] AVS_READDATA_O;
	logic AVS_WAITREQUEST_O, SCL_O, SCL_OE_N_O, SDA_O, SDA_OE_N_O, scl_rel, sda_rel;
	wire logic scl_line;
	wire logic sda_line;
	int fails = 0;
	int n_tests = 0;
	// Open-drain lines with pull-ups
	assign scl_line = (SCL_OE_N_O | SCL_O) & scl_rel;
	assign sda_line = (SDA_OE_N_O | SDA_O) & sda_rel;
	twse_top twse_top_inst (.MCLK_I(MCLK_I), .RST_I(RST_I), .AVS_ADDRESS_I(AVS_ADDRESS_I),
		.AVS_READ_I(AVS_READ_I), .AVS_WRITE_I(AVS_WRITE_I), .AVS_WRITEDATA_I(AVS_WRITEDATA_I),
		.AVS_BYTEENABLE_I(4'hF), .AVS_READDATA_O(AVS_READDATA_O), .AVS_WAITREQUEST_O(AVS_WAITREQUEST_O),
		.SCL_I(scl_line), .SCL_O(SCL_O), .SCL_OE_N_O(SCL_OE_N_O), .SDA_I(sda_line), .SDA_O(SDA_O),
		.SDA_OE_N_O(SDA_OE_N_O));
	twse_bus_model twse_bus_model_inst (.scl_i(scl_line), .sda_i(sda_line), .scl_rel_o(scl_rel),
		.sda_rel_o(sda_rel));
	initial begin
		forever #2.5 MCLK_I = ~MCLK_I;
	end
	task automatic complete_run;
		if (fails == 0 && n_tests > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask
	task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
		n_tests++;
		if (seen !== exp) begin
			fails++;
			$display("unexpected %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	// One Avalon access, held until waitrequest is seen low
	task automatic acc(input logic w, input logic [3:0] a, input logic [7:0] d, output logic [7:0] q);
		int n;
		@(posedge MCLK_I);
		AVS_ADDRESS_I <= a;
		AVS_WRITE_I <= w;
		AVS_READ_I <= !w;
		AVS_WRITEDATA_I <= {24'h000000, d};
		n = 0;
		// Request stands until the rising edge that sees waitrequest low
		do begin
			@(posedge MCLK_I);
			n++;
		end while (AVS_WAITREQUEST_O !== 1'b0 && n < 50);
		if (n >= 50) begin
			fails++;
			complete_run();
		end
		q = AVS_READDATA_O[7:0];
		AVS_WRITE_I <= 1'b0;
		AVS_READ_I <= 1'b0;
	endtask
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		logic [7:0] q;
		acc(1'b1, a, d, q);
	endtask
	task automatic rd(input string nm, input logic [3:0] a, input logic [7:0] exp);
		logic [7:0] q;
		acc(1'b0, a, 8'h00, q);
		chk(nm, q, exp);
	endtask
	// Status polling only; other registers stay untouched meanwhile
	task automatic poll(input logic [7:0] exp);
		logic [7:0] q;
		for (int n = 0; n < 1500; n++) begin
			acc(1'b0, 4'h4, 8'h00, q);
			if (q === exp) break;
		end
		chk("status", q, exp);
		if (q !== exp) begin
			complete_run();
		end
	endtask
	task automatic cnd(input logic f);
		twse_bus_model_inst.cond(f);
	endtask
	task automatic sendb(input logic [7:0] b, input logic a);
		twse_bus_model_inst.xfer(b, 8);
		chk("ack", {7'h00, twse_bus_model_inst.got_ack}, {7'h00, a});
	endtask
	// Reset values
	task automatic t_reset;
		rd("ctrl", 4'h0, 8'h00);
		rd("status", 4'h4, 8'hF8);
		rd("data", 4'h8, 8'h01);
		rd("addr", 4'hC, 8'h02);
		wr(4'h4, 8'h03);
		rd("status", 4'h4, 8'hFB);
		wr(4'h4, 8'h00);
	endtask
	// Own address, one byte, STOP while addressed, then ignored
	task automatic t_recv;
		wr(4'hC, 8'h54);
		wr(4'h0, 8'h44);
		cnd(1'b1);
		sendb(8'h54, 1'b1);
		poll(8'h60);
		chk("scl_oe_n", {7'h00, SCL_OE_N_O}, 8'h00);
		wr(4'h0, 8'hC4);
		sendb(8'hA5, 1'b1);
		poll(8'h80);
		rd("data", 4'h8, 8'hA5);
		wr(4'h0, 8'hC4);
		cnd(1'b0);
		poll(8'hA0);
		wr(4'h0, 8'h84);
		rd("status", 4'h4, 8'hF8);
		cnd(1'b1);
		sendb(8'h54, 1'b0);
		cnd(1'b0);
	endtask
	// START inside the address byte, then recovery
	task automatic t_berr;
		wr(4'h0, 8'h44);
		cnd(1'b1);
		twse_bus_model_inst.xfer(8'h54, 3);
		cnd(1'b1);
		poll(8'h00);
		rd("ctrl", 4'h0, 8'hC4);
		wr(4'h0, 8'hD4);
		rd("ctrl", 4'h0, 8'h44);
		rd("status", 4'h4, 8'hF8);
		chk("oe_n", {6'h00, SCL_OE_N_O, SDA_OE_N_O}, 8'h03);
		cnd(1'b0);
	endtask
	// Broadcast call, restart while addressed, queued START and restart as master
	task automatic t_gca;
		wr(4'hC, 8'h55);
		wr(4'h0, 8'h44);
		cnd(1'b1);
		sendb(8'h00, 1'b1);
		poll(8'h70);
		wr(4'h0, 8'hC4);
		sendb(8'h3C, 1'b1);
		poll(8'h90);
		rd("data", 4'h8, 8'h3C);
		wr(4'h0, 8'hC4);
		cnd(1'b1);
		poll(8'hA0);
		wr(4'h0, 8'hE4);
		sendb(8'h10, 1'b0);
		chk("sda_oe_n", {7'h00, SDA_OE_N_O}, 8'h01);
		cnd(1'b0);
		poll(8'h08);
		wr(4'h0, 8'hA4);
		poll(8'h10);
		chk("scl_oe_n", {7'h00, SCL_OE_N_O}, 8'h00);
		wr(4'h0, 8'h94);
		repeat (3100) @(posedge MCLK_I);
		rd("status", 4'h4, 8'hF8);
		chk("oe_n", {6'h00, SCL_OE_N_O, SDA_OE_N_O}, 8'h03);
	endtask
	initial begin
		repeat (10) @(posedge MCLK_I);
		RST_I <= 1'b0;
		t_reset;
		t_recv;
		t_berr;
		t_gca;
		chk("stalls", 8'(twse_bus_model_inst.stalls), 8'h00);
		complete_run;
	end
endmodule // tb_top
bind twse_top twse_props twse_props_inst (.MCLK_I(MCLK_I), .RST_I(RST_I), .AVS_ADDRESS_I(AVS_ADDRESS_I),
	.AVS_READ_I(AVS_READ_I), .AVS_WRITE_I(AVS_WRITE_I), .AVS_READDATA_O(AVS_READDATA_O),
	.AVS_WAITREQUEST_O(AVS_WAITREQUEST_O), .SCL_I(SCL_I), .SCL_OE_N_O(SCL_OE_N_O), .SDA_OE_N_O(SDA_OE_N_O));
`default_nettype wire
